/* logic/cbbc_pkg.sv */
// package: offsets, field positions, reset values and carrier types of the bridge control block
package cbbc_pkg;

   // ---------------------------------------------------------------
   // register offsets (byte addresses on the apb bus)
   // ---------------------------------------------------------------
   localparam logic [11:0] CBBC_ADR_BRIDGE_CONTROL = 12'h000;  // control word
   localparam logic [11:0] CBBC_ADR_CMD = 12'h004;             // command enables
   localparam logic [11:0] CBBC_ADR_STATUS = 12'h008;          // block state, read only
   localparam logic [11:0] CBBC_ADR_IRQ_SEL = 12'h00C;         // isa irq selection
   localparam logic [11:0] CBBC_ADR_PWRDN = 12'h010;           // power-down request

   // ---------------------------------------------------------------
   // control field positions
   // ---------------------------------------------------------------
   localparam int CBBC_B_IRQ_ISA = 7;      // isa_irq_route_en
   localparam int CBBC_B_CARD_RESET_OUT = 6;         // card_reset_ctl
   localparam int CBBC_B_MABORT = 5;       // master abort mode
   localparam int CBBC_B_RSVD = 4;         // reserved, reads zero
   localparam int CBBC_B_VGA = 3;          // legacy video forwarding
   localparam int CBBC_B_ISA = 2;          // legacy_io_block_en
   localparam int CBBC_B_SERR = 1;         // card_syserr_fwd_en
   localparam int CBBC_B_PERR = 0;         // parity error response

   // command register field positions
   localparam int CBBC_C_IO = 0;           // i/o space enable
   localparam int CBBC_C_MEM = 1;          // memory space enable
   localparam int CBBC_C_SERR = 2;         // system error reporting enable

   // ---------------------------------------------------------------
   // reset values and widths
   // ---------------------------------------------------------------
   localparam logic [7:0] CBBC_CTL_RESET = 8'h00;     // all writable bits clear
   localparam logic [7:0] CBBC_CTL_WMASK = 8'hEF;     // bit 4 not writable
   localparam logic [2:0] CBBC_CMD_RESET = 3'h0;      // command enables clear
   localparam logic [3:0] CBBC_IRQ_RESET = 4'h3;      // default isa irq line
   localparam int CBBC_IRQ_LO = 3;                     // lowest isa irq pin
   localparam int CBBC_IRQ_HI = 15;                    // highest isa irq pin

   // ---------------------------------------------------------------
   // legacy address ranges
   // ---------------------------------------------------------------
   localparam logic [31:0] CBBC_VGA_MEM_LO = 32'h000A_0000;  // video memory start
   localparam logic [31:0] CBBC_VGA_MEM_HI = 32'h000B_FFFF;  // video memory end
   localparam logic [9:0] CBBC_VGA_IO1_LO = 10'h3B0;         // mono io start
   localparam logic [9:0] CBBC_VGA_IO1_HI = 10'h3BB;         // mono io end
   localparam logic [9:0] CBBC_VGA_IO2_LO = 10'h3C0;         // colour io start
   localparam logic [9:0] CBBC_VGA_IO2_HI = 10'h3DF;         // colour io end
   localparam logic [9:0] CBBC_ISA_BLK_LO = 10'h100;         // upper 768 bytes of 1k
   localparam logic [15:0] CBBC_IO_64K_TOP = 16'hFFFF;       // first 64 kbytes
   localparam logic [31:0] CBBC_ONES = 32'hFFFF_FFFF;        // aborted read data

   // ---------------------------------------------------------------
   // carrier types
   // ---------------------------------------------------------------
   typedef struct packed
   {
      logic valid;        // decode request present
      logic from_card;    // 1: originates on card-side bus
      logic is_io;        // 1: i/o, 0: memory
      logic [31:0] addr;  // transaction address
   } cbbc_xact_t;

   typedef struct packed
   {
      logic fwd;          // forward to opposite bus
      logic claim;        // respond on originating bus
   } cbbc_route_t;

   typedef struct packed
   {
      logic valid;        // master abort seen on destination
      logic is_read;      // aborted transaction was a read
      logic posted;       // write was posted
      logic [3:0] be;     // byte enables of the source
   } cbbc_abort_t;

endpackage : cbbc_pkg

/* logic/cbbc_bridge_control.sv */
// top: bridge control low byte with apb register access and routing logic
`timescale 1ns/1ps
// What this block does
// - bit 7 set: card interrupt to isa pin
// - bit 7 clear: card interrupt to inta
// - bit 6 holds card reset asserted
// - power-down sequence sets bit 6 itself
// - card reset is bit 6 or pci reset
// - bit 5 clear: abort gives ones, drops writes
// - bit 5 set: abort gives target abort, posted writes dropped
// - bit 4 reads zero, ignores writes
// - bit 3: forward video memory range to card
// - bit 3: forward video io, ten bits decoded
// - card-side video range gets no response
// - video forwarding gated by command enables
// - bit 2: pci io only 64k, block upper 768
// - bit 2: card io upper 768 goes to pci
// - bit 1 passes card system error to serr
// - bit 0 reports or ignores card parity errors
// - bits 7,5,3,2,1,0 reset to zero
module cbbc_bridge_control
   import cbbc_pkg::*;
(
   // clock and reset
   input wire logic CLK_I,
   input wire logic RESET_I,
   // apb slave
   input wire logic PSEL_I,
   input wire logic PENABLE_I,
   input wire logic PWRITE_I,
   input wire logic [11:0] PADDR_I,
   input wire logic [31:0] PWDATA_I,
   output logic [31:0] PRDATA_O,
   output logic PREADY_O,
   output logic PSLVERR_O,
   // hardware events
   input wire logic PWRDN_SEQ_I,
   input wire logic CARD_IRQ_REQUEST_I,
   input wire logic CARD_SYSTEM_ERROR_I,
   input wire logic CARD_PARITY_ERR_I,
   // transaction decode
   input wire cbbc_xact_t XACT_I,
   output cbbc_route_t ROUTE_O,
   // master abort handling
   input wire cbbc_abort_t ABORT_I,
   output logic [31:0] ABORT_RDATA_O,
   output logic TARGET_ABORT_O,
   output logic DISCARD_WRITE_O,
   // outputs toward pins
   output logic [CBBC_IRQ_HI:CBBC_IRQ_LO] ISA_IRQ_O,
   output logic INTA_O,
   output logic CARD_RESET_OUT_O,
   output logic SERR_O,
   output logic PERR_REPORT_O
);

   // ------------------------------------------------------------
   // pin input synchronisers
   // ------------------------------------------------------------
   logic [3:0] pin_s1_r;   // first stage, read only by second
   logic [3:0] pin_s2_r;   // second stage
   logic [3:0] pin_s3_r;   // third stage
   logic [3:0] pin_q_r;    // agreed level
   wire logic [3:0] pin_raw = {CARD_PARITY_ERR_I, CARD_SYSTEM_ERROR_I,
                               CARD_IRQ_REQUEST_I, PWRDN_SEQ_I};

   // stage one may go metastable; only stage two reads it, so a whole
   // clock period of settling time is kept
   // three stages; a change counts once stages two and three agree
   always_ff @(posedge CLK_I)
   begin
      pin_s1_r <= pin_raw;
      pin_s2_r <= pin_s1_r;
      pin_s3_r <= pin_s2_r;
   end

   genvar gi;
   generate
      for (gi = 0; gi < 4; gi++)
      begin : g_agree
         // agreement filter per pin
         // a one-cycle glitch on a pin never reaches the block
         // because two stages must show the same level first
         always_ff @(posedge CLK_I)
         begin
            if (RESET_I)
               pin_q_r[gi] <= 1'b0;
            else if (pin_s2_r[gi] == pin_s3_r[gi])
               pin_q_r[gi] <= pin_s3_r[gi];
         end
      end
   endgenerate

   wire logic pwrdn_lvl = pin_q_r[0];    // power-down sequence running
   wire logic irq_lvl = pin_q_r[1];      // card_irq_request / cardbus_func_int
   wire logic card_system_error_lvl = pin_q_r[2];    // card_system_error
   wire logic cperr_lvl = pin_q_r[3];    // card-side parity error

   // ------------------------------------------------------------
   // registers
   // ------------------------------------------------------------
   logic [7:0] ctl_r;        // bridge_control low byte
   logic [7:0] ctl_nxt;      // next control value
   logic [2:0] cmd_r;        // command enables
   logic [3:0] irq_sel_r;    // isa irq line selection
   logic pwrdn_d_r;          // delayed power-down level

   // apb decode
   // a write lands only at the edge where the master sees ready; a held
   // access phase sees ready every second cycle and writes again each time
   wire logic wr_acc = PSEL_I & PENABLE_I & PWRITE_I & PREADY_O;
   wire logic sel_ctl = (PADDR_I == CBBC_ADR_BRIDGE_CONTROL);
   wire logic sel_cmd = (PADDR_I == CBBC_ADR_CMD);
   wire logic sel_sts = (PADDR_I == CBBC_ADR_STATUS);
   wire logic sel_irq = (PADDR_I == CBBC_ADR_IRQ_SEL);
   wire logic sel_pwr = (PADDR_I == CBBC_ADR_PWRDN);
   wire logic mapped = sel_ctl | sel_cmd | sel_sts | sel_irq | sel_pwr;
   wire logic pwrdn_rise = pwrdn_lvl & ~pwrdn_d_r;
   wire logic sw_pwrdn = wr_acc & sel_pwr & PWDATA_I[0];

   // a power-down must never be lost to a software write in the same
   // cycle, so the hardware set is applied last
   // control next value: software write, then hardware set wins
   always_comb
   begin
      ctl_nxt = ctl_r;
      if (wr_acc & sel_ctl)
         ctl_nxt = PWDATA_I[7:0] & CBBC_CTL_WMASK;
      if (pwrdn_rise | sw_pwrdn)
         ctl_nxt[CBBC_B_CARD_RESET_OUT] = 1'b1;
      ctl_nxt[CBBC_B_RSVD] = 1'b0;
   end

   // register storage
   // command and irq selection change only on a mapped write
   // at the ready edge; the control byte goes through ctl_nxt
   always_ff @(posedge CLK_I)
   begin
      if (RESET_I)
      begin
         ctl_r <= CBBC_CTL_RESET;
         cmd_r <= CBBC_CMD_RESET;
         irq_sel_r <= CBBC_IRQ_RESET;
         pwrdn_d_r <= 1'b0;
      end
      else
      begin
         ctl_r <= ctl_nxt;
         pwrdn_d_r <= pwrdn_lvl;
         if (wr_acc & sel_cmd)
            cmd_r <= PWDATA_I[2:0];
         if (wr_acc & sel_irq)
            irq_sel_r <= PWDATA_I[3:0];
      end
   end

   // read mux; status shows live block state
   logic [31:0] rd_mux;
   always_comb
   begin
      rd_mux = 32'h0000_0000;
      if (sel_ctl)
         rd_mux = {24'h00_0000, ctl_r};
      else if (sel_cmd)
         rd_mux = {29'h0000_0000, cmd_r};
      else if (sel_irq)
         rd_mux = {28'h000_0000, irq_sel_r};
      else if (sel_sts)
         rd_mux = {27'h000_0000, CARD_RESET_OUT_O, cperr_lvl, card_system_error_lvl,
                   irq_lvl, pwrdn_lvl};
   end

   // apb answer: one wait state, error on unmapped address
   // ready drops after one cycle, but a held access phase
   // gets ready again every second cycle
   always_ff @(posedge CLK_I)
   begin
      if (RESET_I)
      begin
         PREADY_O <= 1'b0;
         PRDATA_O <= 32'h0000_0000;
         PSLVERR_O <= 1'b0;
      end
      else
      begin
         PREADY_O <= PSEL_I & PENABLE_I & ~PREADY_O;
         PRDATA_O <= rd_mux;
         PSLVERR_O <= PSEL_I & PENABLE_I & ~PREADY_O & ~mapped;
      end
   end

   // ------------------------------------------------------------
   // transaction decode
   // ------------------------------------------------------------
   // i/o decode looks at the low ten bits; bits 15:10 alias, bits 31:16 are checked for video and host-side blocking
   wire logic [9:0] io10 = XACT_I.addr[9:0];
   wire logic vga_mem = ~XACT_I.is_io & (XACT_I.addr >= CBBC_VGA_MEM_LO)
                        & (XACT_I.addr <= CBBC_VGA_MEM_HI);
   wire logic vga_io = XACT_I.is_io & (XACT_I.addr[31:16] == 16'h0000) &
                       (((io10 >= CBBC_VGA_IO1_LO) & (io10 <= CBBC_VGA_IO1_HI)) |
                        ((io10 >= CBBC_VGA_IO2_LO) & (io10 <= CBBC_VGA_IO2_HI)));
   wire logic vga_hit = ctl_r[CBBC_B_VGA] &
                        ((vga_mem & cmd_r[CBBC_C_MEM]) | (vga_io & cmd_r[CBBC_C_IO]));
   wire logic io_first64k = XACT_I.addr[31:16] == 16'h0000;
   wire logic io_upper768 = io10 >= CBBC_ISA_BLK_LO;
   wire logic isa_on = ctl_r[CBBC_B_ISA];
   logic fwd_nxt;
   logic claim_nxt;

   // card-side requests in the video ranges get no answer; only the
   // upper i/o blocks go up to pci when legacy blocking is on
   // route decision for one request
   always_comb
   begin
      fwd_nxt = 1'b0;
      claim_nxt = 1'b0;
      if (XACT_I.valid & ~XACT_I.from_card)
      begin
         if (vga_hit)
            fwd_nxt = 1'b1;
         else if (XACT_I.is_io & isa_on)
            fwd_nxt = cmd_r[CBBC_C_IO] & io_first64k & ~io_upper768;
         else if (XACT_I.is_io)
            fwd_nxt = cmd_r[CBBC_C_IO];
         claim_nxt = fwd_nxt;
      end
      else if (XACT_I.valid)
      begin
         if (vga_hit)
            fwd_nxt = 1'b0;
         else if (XACT_I.is_io & isa_on & io_upper768)
            fwd_nxt = 1'b1;
         claim_nxt = fwd_nxt;
      end
   end

   // byte lanes expanded to bits
   wire logic [31:0] lane_mask = {{8{ABORT_I.be[3]}}, {8{ABORT_I.be[2]}},
                                  {8{ABORT_I.be[1]}}, {8{ABORT_I.be[0]}}};

   // posted writes have no master left to abort toward, so they are dropped
   // registered route and abort outcome
   always_ff @(posedge CLK_I)
   begin
      if (RESET_I)
      begin
         ROUTE_O <= '0;
         ABORT_RDATA_O <= 32'h0000_0000;
         TARGET_ABORT_O <= 1'b0;
         DISCARD_WRITE_O <= 1'b0;
      end
      else
      begin
         ROUTE_O <= '{fwd: fwd_nxt, claim: claim_nxt};
         ABORT_RDATA_O <= 32'h0000_0000;
         TARGET_ABORT_O <= 1'b0;
         DISCARD_WRITE_O <= 1'b0;
         if (ABORT_I.valid & ~ctl_r[CBBC_B_MABORT])
         begin
            ABORT_RDATA_O <= ABORT_I.is_read ? (CBBC_ONES & lane_mask) : 32'h0000_0000;
            DISCARD_WRITE_O <= ~ABORT_I.is_read;
         end
         else if (ABORT_I.valid & (ABORT_I.is_read | ~ABORT_I.posted))
            TARGET_ABORT_O <= 1'b1;
         else if (ABORT_I.valid)
            DISCARD_WRITE_O <= 1'b1;
      end
   end

   // ------------------------------------------------------------
   // pin outputs
   // ------------------------------------------------------------
   wire logic mabort_serr = ABORT_I.valid & ctl_r[CBBC_B_MABORT] &
                            (ABORT_I.is_read | ~ABORT_I.posted) & cmd_r[CBBC_C_SERR];
   wire logic card_system_error_fwd = card_system_error_lvl & ctl_r[CBBC_B_SERR];
   wire logic isa_route = ctl_r[CBBC_B_IRQ_ISA];

   // the reset branch holds card reset high, which is the or with pci
   // reset; outside reset the pin follows the next control value
   // interrupt steering, reset, error outputs
   always_ff @(posedge CLK_I)
   begin
      if (RESET_I)
      begin
         ISA_IRQ_O <= '0;
         INTA_O <= 1'b0;
         CARD_RESET_OUT_O <= 1'b1;
         SERR_O <= 1'b0;
         PERR_REPORT_O <= 1'b0;
      end
      else
      begin
         for (int k = CBBC_IRQ_LO; k <= CBBC_IRQ_HI; k++)
            ISA_IRQ_O[k] <= isa_route & irq_lvl & (irq_sel_r == 4'(k));
         INTA_O <= ~isa_route & irq_lvl;
         CARD_RESET_OUT_O <= ctl_nxt[CBBC_B_CARD_RESET_OUT];
         SERR_O <= card_system_error_fwd | mabort_serr;
         PERR_REPORT_O <= cperr_lvl & ctl_r[CBBC_B_PERR];
      end
   end

endmodule : cbbc_bridge_control

/* verif/cbbc_card_model.sv */
// far side model: host power-down request and card event pins
`timescale 1ns/1ps
module cbbc_card_model
(
   // clock
   input wire logic clk_i,
   // requested levels: power-down, irq, system error, parity error
   input wire logic [3:0] evt_i,
   // pins toward the bridge
   output logic pwrdn_o,
   output logic irq_o,
   output logic card_system_error_o,
   output logic perr_o
);
   // pins change just after a clock edge, like a real card
   always_ff @(posedge clk_i)
   begin
      {pwrdn_o, irq_o, card_system_error_o, perr_o} <= evt_i;
   end
endmodule : cbbc_card_model

/* verif/cbbc_bridge_control_props.sv */
// checker: port-level properties of the bridge control block
`timescale 1ns/1ps
module cbbc_bridge_control_props
   import cbbc_pkg::*;
(
   // clock and reset
   input wire logic CLK_I,
   input wire logic RESET_I,
   // apb handshake
   input wire logic PSEL_I,
   input wire logic PENABLE_I,
   input wire logic PREADY_O,
   input wire logic PSLVERR_O,
   // decode and abort
   input wire cbbc_xact_t XACT_I,
   input wire cbbc_route_t ROUTE_O,
   input wire cbbc_abort_t ABORT_I,
   input wire logic [31:0] ABORT_RDATA_O,
   input wire logic TARGET_ABORT_O,
   input wire logic DISCARD_WRITE_O,
   // pins
   input wire logic [CBBC_IRQ_HI:CBBC_IRQ_LO] ISA_IRQ_O,
   input wire logic INTA_O,
   input wire logic CARD_RESET_OUT_O
);
   default clocking cb @(posedge CLK_I); endclocking
   default disable iff (RESET_I);
   // -------------------------------------------------------------
   // helper: abort request of the previous cycle
   // -------------------------------------------------------------
   cbbc_abort_t ab_r; // last abort seen
   wire [31:0] lane_w = {{8{ab_r.be[3]}}, {8{ab_r.be[2]}}, {8{ab_r.be[1]}}, {8{ab_r.be[0]}}};
   always_ff @(posedge CLK_I)
   begin
      ab_r <= ABORT_I;
   end
   // -------------------------------------------------------------
   // assertions
   // -------------------------------------------------------------
   rst_pins_a: assert property ($fell(RESET_I) |-> CARD_RESET_OUT_O ##1 !CARD_RESET_OUT_O)
      else $error("card reset not tied to bus reset");
   ready_pulse_a: assert property (PREADY_O |-> $past(PSEL_I && PENABLE_I) ##1 !PREADY_O)
      else $error("ready without access or too long");
   slverr_pair_a: assert property (PSLVERR_O |-> PREADY_O)
      else $error("error without ready");
   abort_ta_a: assert property (TARGET_ABORT_O |-> ab_r.valid && !DISCARD_WRITE_O)
      else $error("target abort without cause");
   abort_drop_a: assert property (DISCARD_WRITE_O |-> ab_r.valid && !ab_r.is_read)
      else $error("discard without aborted write");
   abort_lanes_a: assert property (ABORT_RDATA_O != '0 |-> ab_r.is_read && ABORT_RDATA_O == lane_w)
      else $error("aborted read data lanes wrong");
   irq_excl_a: assert property ($onehot0(ISA_IRQ_O) && !(INTA_O && ISA_IRQ_O != '0))
      else $error("interrupt routed twice");
   route_cause_a: assert property ((ROUTE_O.fwd || ROUTE_O.claim) |-> $past(XACT_I.valid))
      else $error("route without transaction");
   // covers
   ta_seen_c: cover property (TARGET_ABORT_O);
   ones_seen_c: cover property (ABORT_RDATA_O != '0);
   isa_seen_c: cover property (ISA_IRQ_O != '0);
endmodule : cbbc_bridge_control_props

bind cbbc_bridge_control cbbc_bridge_control_props u_cbbc_bridge_control_props (
   .CLK_I(CLK_I), .RESET_I(RESET_I), .PSEL_I(PSEL_I), .PENABLE_I(PENABLE_I),
   .PREADY_O(PREADY_O), .PSLVERR_O(PSLVERR_O), .XACT_I(XACT_I), .ROUTE_O(ROUTE_O),
   .ABORT_I(ABORT_I), .ABORT_RDATA_O(ABORT_RDATA_O), .TARGET_ABORT_O(TARGET_ABORT_O),
   .DISCARD_WRITE_O(DISCARD_WRITE_O), .ISA_IRQ_O(ISA_IRQ_O), .INTA_O(INTA_O),
   .CARD_RESET_OUT_O(CARD_RESET_OUT_O));

/* verif/cbbc_bridge_control_tb_top.sv */
// testbench: registers, routing, aborts and pins of the bridge control block
`timescale 1ns/1ps
module cbbc_bridge_control_tb_top;
   import cbbc_pkg::*;
   // ---------------------------------------------------------------
   // signals
   // ---------------------------------------------------------------
   typedef struct packed
   {
      logic [7:0] ctl;   // control byte
      logic [2:0] cmd;   // command enables
      cbbc_xact_t xact;  // offered transaction
      cbbc_route_t exp;  // expected route
      cbbc_route_t msk;  // compared route bits
   } cbbc_row_t;
   cbbc_row_t rows [11];
   logic clk, rst, psel, penable, pwrite, pready, pslverr, err, ta, dw, inta, card_reset_out, serr, prep;
   logic pwrdn, irq, card_system_error, perr;
   logic [3:0] evt;
   logic [11:0] paddr;
   logic [31:0] pwdata, prdata, ardata, rd;
   logic [CBBC_IRQ_HI:CBBC_IRQ_LO] isa;
   cbbc_xact_t xact;
   cbbc_route_t route;
   cbbc_abort_t abrt;
   int mismatches, checks, cycles;
   // ---------------------------------------------------------------
   // design and far side
   // ---------------------------------------------------------------
   cbbc_bridge_control u_cbbc_bridge_control (.CLK_I(clk), .RESET_I(rst), .PSEL_I(psel),
      .PENABLE_I(penable), .PWRITE_I(pwrite), .PADDR_I(paddr), .PWDATA_I(pwdata),
      .PRDATA_O(prdata), .PREADY_O(pready), .PSLVERR_O(pslverr), .PWRDN_SEQ_I(pwrdn),
      .CARD_IRQ_REQUEST_I(irq), .CARD_SYSTEM_ERROR_I(card_system_error), .CARD_PARITY_ERR_I(perr),
      .XACT_I(xact), .ROUTE_O(route), .ABORT_I(abrt), .ABORT_RDATA_O(ardata),
      .TARGET_ABORT_O(ta), .DISCARD_WRITE_O(dw), .ISA_IRQ_O(isa), .INTA_O(inta),
      .CARD_RESET_OUT_O(card_reset_out), .SERR_O(serr), .PERR_REPORT_O(prep));
   cbbc_card_model u_cbbc_card_model (.clk_i(clk), .evt_i(evt), .pwrdn_o(pwrdn), .irq_o(irq),
      .card_system_error_o(card_system_error), .perr_o(perr));
   // ---------------------------------------------------------------
   // clock, timeout and shared tasks
   // ---------------------------------------------------------------
   initial
   begin
      clk = 1'b0;
      forever #20 clk = ~clk;
   end
   // hang guard: far beyond the few hundred cycles the run needs
   always @(posedge clk)
   begin
      cycles++;
      if (cycles == 20000)
      begin
         mismatches++;
         results();
      end
   end
   task results;
      $display("checks %0d mismatches %0d", checks, mismatches);
      if (mismatches == 0 && checks > 0)
         $display("All checks passed");
      else
         $display("Checks failed");
      $finish;
   endtask : results
   task chk(input string name, input logic [31:0] exp, input logic [31:0] got);
      checks++;
      if (got !== exp)
      begin
         mismatches++;
         $display("unexpected %s: expected %h seen %h", name, exp, got);
      end
   endtask : chk
   // one apb transfer; data and error taken at the ready edge
   task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
      @(posedge clk);
      {psel, penable, pwrite, paddr, pwdata} <= {1'b1, 1'b0, w, a, d};
      @(posedge clk);
      penable <= 1'b1;
      do @(posedge clk); while (pready !== 1'b1);
      rd = prdata;
      err = pslverr;
      {psel, penable} <= 2'h0;
   endtask : apb
   // ---------------------------------------------------------------
   // main sequence
   // ---------------------------------------------------------------
   initial
   begin
      {rst, psel, penable, pwrite, paddr, pwdata, evt, xact, abrt} = {1'b1, 93'h0};
      {mismatches, checks, cycles} = 0;
      // ctl, cmd, valid, from card, io, address, expected fwd/claim, mask
      rows[0] = {8'h08, 3'h2, 3'h4, 32'h000A_0000, 2'h2, 2'h2};
      rows[1] = {8'h08, 3'h2, 3'h4, 32'h000B_FFFF, 2'h2, 2'h2};
      rows[2] = {8'h08, 3'h0, 3'h4, 32'h000A_0000, 2'h0, 2'h2};
      rows[3] = {8'h08, 3'h1, 3'h5, 32'h0000_FBB0, 2'h2, 2'h2};
      rows[4] = {8'h08, 3'h1, 3'h5, 32'h0000_F3DF, 2'h2, 2'h2};
      rows[5] = {8'h08, 3'h0, 3'h5, 32'h0000_03C0, 2'h0, 2'h2};
      rows[6] = {8'h08, 3'h3, 3'h6, 32'h000A_0000, 2'h0, 2'h3};
      rows[7] = {8'h04, 3'h1, 3'h5, 32'h0000_0500, 2'h0, 2'h2};
      rows[8] = {8'h04, 3'h1, 3'h5, 32'h0001_0000, 2'h0, 2'h2};
      rows[9] = {8'h04, 3'h1, 3'h5, 32'h0000_04FF, 2'h2, 2'h2};
      rows[10] = {8'h04, 3'h1, 3'h7, 32'h0000_0200, 2'h2, 2'h2};
      repeat (16) @(posedge clk);
      #1 chk("card reset in reset", 1, card_reset_out);
      @(posedge clk) rst <= 1'b0;
      apb(1'b0, CBBC_ADR_BRIDGE_CONTROL, 0);
      chk("control reset", 0, rd);
      chk("card reset released", 0, card_reset_out);
      apb(1'b1, CBBC_ADR_BRIDGE_CONTROL, 32'h0000_00FF);
      apb(1'b0, CBBC_ADR_BRIDGE_CONTROL, 0);
      chk("control readback", 32'h0000_00EF, rd);
      chk("card reset by bit", 1, card_reset_out);
      apb(1'b1, CBBC_ADR_BRIDGE_CONTROL, 0);
      apb(1'b0, 12'hFFC, 0);
      chk("unmapped error", 1, err);
      chk("card reset cleared", 0, card_reset_out);
      // routing table; host keeps the card isa-route enable clear
      foreach (rows[i])
      begin
         apb(1'b1, CBBC_ADR_BRIDGE_CONTROL, {24'h0, rows[i].ctl});
         apb(1'b1, CBBC_ADR_CMD, {29'h0, rows[i].cmd});
         xact <= rows[i].xact;
         @(posedge clk) xact <= '0;
         #1 chk("route", {30'h0, rows[i].exp & rows[i].msk}, {30'h0, route & rows[i].msk});
      end
      // aborts: both modes, read, non-posted and posted write
      apb(1'b1, CBBC_ADR_CMD, 32'h0000_0004);
      for (int m = 0; m < 2; m++)
      begin
         for (int k = 0; k < 3; k++)
         begin
            apb(1'b1, CBBC_ADR_BRIDGE_CONTROL, m ? 32'h0000_0020 : 32'h0000_0000);
            abrt <= {1'b1, k == 0, k == 2, 4'h5};
            @(posedge clk) abrt <= '0;
            #1 chk("abort data", (m == 0 && k == 0) ? 32'h00FF_00FF : 32'h0, ardata);
            chk("target abort", m == 1 && k != 2, ta);
            chk("discard", k != 0 && (m == 0 || k == 2), dw);
            chk("abort serr", m == 1 && k != 2, serr);
         end
      end
      // interrupt steering to isa pin 5, then to inta
      apb(1'b1, CBBC_ADR_IRQ_SEL, 32'h0000_0005);
      apb(1'b1, CBBC_ADR_BRIDGE_CONTROL, 32'h0000_0080);
      evt <= 4'h4;
      repeat (8) @(posedge clk);
      #1 chk("isa irq", 32'h0000_0004, {19'h0, isa});
      chk("inta off", 0, inta);
      apb(1'b1, CBBC_ADR_BRIDGE_CONTROL, 0);
      repeat (8) @(posedge clk);
      #1 chk("inta", 1, inta);
      chk("isa irq off", 0, {19'h0, isa});
      // system and parity error forwarding on, then off
      evt <= 4'h3;
      apb(1'b1, CBBC_ADR_BRIDGE_CONTROL, 32'h0000_0003);
      repeat (8) @(posedge clk);
      #1 chk("serr", 1, serr);
      chk("parity report", 1, prep);
      apb(1'b1, CBBC_ADR_BRIDGE_CONTROL, 0);
      repeat (8) @(posedge clk);
      #1 chk("serr off", 0, serr);
      chk("parity off", 0, prep);
      // power-down sets the card reset bit by itself
      evt <= 4'h8;
      repeat (8) @(posedge clk);
      apb(1'b0, CBBC_ADR_BRIDGE_CONTROL, 0);
      chk("powerdown bit", 1, rd[6]);
      chk("powerdown card reset", 1, card_reset_out);
      evt <= 4'h0;
      apb(1'b1, CBBC_ADR_BRIDGE_CONTROL, 0);
      apb(1'b0, CBBC_ADR_STATUS, 0);
      chk("card reset freed", 0, card_reset_out);
      chk("status idle", 0, rd);
      apb(1'b1, CBBC_ADR_PWRDN, 32'h0000_0001);
      apb(1'b0, CBBC_ADR_BRIDGE_CONTROL, 0);
      chk("soft powerdown bit", 32'h0000_0040, rd);
      chk("soft powerdown card reset", 1, card_reset_out);
      // second reset in mid-run
      apb(1'b1, CBBC_ADR_BRIDGE_CONTROL, 32'h0000_00AF);
      rst <= 1'b1;
      repeat (3) @(posedge clk);
      #1 chk("card reset rerun", 1, card_reset_out);
      @(posedge clk) rst <= 1'b0;
      apb(1'b0, CBBC_ADR_BRIDGE_CONTROL, 0);
      chk("control reset rerun", 0, rd);
      results();
   end
endmodule : cbbc_bridge_control_tb_top
